/* File: ide_timing_consts.vh */
// constants for the ide channel timing control block
`ifndef IDE_TIMING_CONSTS_VH
`define IDE_TIMING_CONSTS_VH

// register indices; byte address is four times the index
`define IDX_BUS_MASTER_TUNING 8'h44
`define IDX_INTERRUPT_STEERING 8'h45
`define IDX_FIFO_FLUSH_CONTROL 8'h46
`define IDX_STROBE_TIMING 8'h48
`define IDX_ADDRESS_SETUP 8'h4C
`define IDX_SEC_TASKFILE_TIMING 8'h4E
`define IDX_PRI_TASKFILE_TIMING 8'h4F
`define IDX_SYNC_DMA_TIMING 8'h50
`define IDX_PRI_SECTOR_BYTES 8'h60
`define IDX_SEC_SECTOR_BYTES 8'h68

// bus master tuning fields
`define BMT_READ_WAIT 6
`define BMT_WRITE_WAIT 5
`define BMT_FIFO_ADVANCE 4
`define BMT_STATUS_RETRY 3
`define BMT_MASK 8'h7B
`define BMT_RESET 8'h68

// interrupt steering fields
`define STEER_SWAP 6
`define STEER_MASK 8'h40
`define STEER_RESET 8'h00

// fifo flush control fields
`define FLUSH_PRI_READ 7
`define FLUSH_SEC_READ 6
`define FLUSH_PRI_SECTOR 5
`define FLUSH_SEC_SECTOR 4
`define FLUSH_LIMIT_HI 1
`define FLUSH_LIMIT_LO 0
`define FLUSH_MASK 8'hF3
`define FLUSH_RESET 8'h00
`define READY_LIMIT_STEP 8'h40

// strobe, setup and task file timing
`define STROBE_RESET 32'hA8A8_A8A8
`define SETUP_RESET 8'hFF
`define TASKFILE_RESET 8'hF0

// sync dma timing, one byte per drive
`define SDMA_METHOD 7
`define SDMA_ENABLE 6
`define SDMA_MODE 5
`define SDMA_RW_MASK 32'hC3C3_C3C3
`define SDMA_RESET 32'h0303_0303
`define SDMA_CYCLE_BASE 3'h2

// sector size
`define SECTOR_MASK 16'h0FFF
`define SECTOR_RESET 12'h200
`define BYTES_PER_WORD 12'h002

// sequencer states
`define SEQ_IDLE 2'h0
`define SEQ_SETUP 2'h1
`define SEQ_ACTIVE 2'h2
`define SEQ_RECOVER 2'h3

`endif

/* File: ide_strobe_sequencer.v */
// one channel's drive strobe sequencer: address setup, active width, recovery
`include "ide_timing_consts.vh"
module ide_strobe_sequencer (
  input wire ref_clk, // 100 mhz clock
  input wire rst, // async reset, active high
  input wire start, // one-cycle request to run a strobe
  input wire write, // 1 write strobe, 0 read strobe
  input wire [1:0] setup_code, // address setup code, clocks minus one
  input wire [3:0] active_code, // active width, clocks minus one
  input wire [3:0] recovery_code, // recovery, clocks minus one
  input wire [7:0] ready_limit, // hang limit in clocks, zero for none
  input wire ready_ok, // synchronised: drive not holding ready low
  output reg read_strobe_n, // drive read strobe, active low
  output reg write_strobe_n, // drive write strobe, active low
  output reg busy, // sequence in progress
  output reg done, // one-cycle pulse at end of recovery
  output reg hang_break // one-cycle pulse when the limit cut a strobe
);
  reg [1:0] state;
  reg [3:0] count;
  reg [7:0] wait_count;
  reg is_write;
  reg [3:0] active_hold;
  reg [3:0] recovery_hold;

  wire limit_hit = (ready_limit != 8'h00) && (wait_count >= ready_limit - 8'h01);

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state <= `SEQ_IDLE;
      count <= 4'h0;
      wait_count <= 8'h00;
      is_write <= 1'b0;
      active_hold <= 4'h0;
      recovery_hold <= 4'h0;
      read_strobe_n <= 1'b1;
      write_strobe_n <= 1'b1;
      busy <= 1'b0;
      done <= 1'b0;
      hang_break <= 1'b0;
    end else begin
      done <= 1'b0;
      hang_break <= 1'b0;
      case (state)
        `SEQ_IDLE: begin
          if (start) begin
            is_write <= write;
            active_hold <= active_code;
            recovery_hold <= recovery_code;
            count <= {2'b00, setup_code};
            busy <= 1'b1;
            state <= `SEQ_SETUP;
          end
        end
        `SEQ_SETUP: begin
          if (count == 4'h0) begin
            count <= active_hold;
            wait_count <= 8'h00;
            read_strobe_n <= is_write;
            write_strobe_n <= ~is_write;
            state <= `SEQ_ACTIVE;
          end else begin
            count <= count - 4'h1;
          end
        end
        `SEQ_ACTIVE: begin
          if (wait_count != 8'hFF) begin
            wait_count <= wait_count + 8'h01;
          end
          if (count != 4'h0) begin
            count <= count - 4'h1;
          end else if (ready_ok || limit_hit) begin
            hang_break <= ~ready_ok;
            read_strobe_n <= 1'b1;
            write_strobe_n <= 1'b1;
            count <= recovery_hold;
            state <= `SEQ_RECOVER;
          end
        end
        `SEQ_RECOVER: begin
          if (count == 4'h0) begin
            busy <= 1'b0;
            done <= 1'b1;
            state <= `SEQ_IDLE;
          end else begin
            count <= count - 4'h1;
          end
        end
        default: begin
          state <= `SEQ_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end
endmodule // ide_strobe_sequencer

/* File: ide_channel_timing_control.v */
// register bank and timing control for a two-channel bus-mastering ide controller
// Summary of operation
// - master read inserts one initiator-ready wait state when tuning bit 6 set
// - master write inserts one initiator-ready wait state when tuning bit 5 set
// - tuning bit 4 presents fifo output data half a clock early
// - tuning bit 3 retries status reads while dma-read master write pending
// - steering swap bit exchanges primary and secondary interrupt outputs
// - read dma flush bits flush channel fifo when channel interrupt asserts
// - end-of-sector flush bits flush channel fifo after every sector
// - strobe ends after 64, 128 or 192 clocks despite drive ready low
// - strobe timing register: active and recovery nibble per drive, pri drive 0 top
// - active width and recovery last field value plus one clocks
// - two-bit address setup per drive gives one to four clocks
// - per-channel task file timing upper nibble sets strobe active width
// - method bit: clear follows set-features detection, set follows enable bit
// - per-drive enable bit switches synchronous dma on
// - read-only transfer mode bit: 0 sync dma based, 1 pio based
// - cycle time field gives two to five clocks per sync dma cycle
// - sync dma register uses one byte per drive, unused bits read zero
// - twelve-bit bytes per sector per channel, default 200h, top bits zero
//
// The APB interface to the registers was decided locally.
`include "ide_timing_consts.vh"
module ide_channel_timing_control (
  input wire ref_clk, // 100 mhz clock
  input wire rst, // async reset, active high
  input wire psel, // apb select
  input wire penable, // apb access phase
  input wire pwrite, // apb direction
  input wire [9:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output reg [31:0] prdata, // apb read data
  output reg pready, // apb ready
  output reg pslverr, // apb error on unmapped address
  input wire status_read_req, // host reads bus master status register
  input wire dma_write_pending, // master write for dma read not complete
  output reg status_read_retry, // answer the status read with retry
  output wire read_irdy_wait, // one wait state on master reads
  output wire write_irdy_wait, // one wait state on master writes
  output wire fifo_data_advance, // fifo data half clock early
  input wire [1:0] channel_irq, // raw interrupt, bit0 primary
  output reg [1:0] irq_out, // steered interrupt, bit0 primary output
  output reg [1:0] fifo_flush, // one-cycle flush pulse per channel
  input wire [1:0] word_moved, // one 16-bit word moved on a channel
  input wire [1:0] cmd_start, // start a drive strobe on a channel
  input wire [1:0] cmd_write, // strobe direction per channel
  input wire [1:0] cmd_drive, // drive select per channel
  input wire [1:0] cmd_taskfile, // access is to a non-data task file port
  input wire [1:0] drive_ready_wait_n, // drive ready pins, low holds strobe
  output wire [1:0] drive_read_strobe_n, // read strobe per channel, active low
  output wire [1:0] drive_write_strobe_n, // write strobe per channel, active low
  output wire [1:0] strobe_busy, // sequencer busy per channel
  output wire [1:0] strobe_done, // sequencer finished pulse
  output wire [1:0] strobe_hang_break, // strobe cut by hang limit pulse
  input wire [3:0] set_features_on, // set-features enabling sync dma, per drive
  input wire [3:0] set_features_off, // set-features disabling sync dma, per drive
  input wire [3:0] pio_based, // drive timing currently pio based
  output reg [3:0] sync_dma_active, // sync dma mode per drive
  output reg [11:0] sync_dma_cycle // cycle clocks per drive, 3 bits each
);
  reg [7:0] bus_master_tuning;
  reg [7:0] interrupt_steering;
  reg [7:0] fifo_flush_control;
  reg [31:0] strobe_timing;
  reg [7:0] address_setup;
  reg [7:0] sec_taskfile_timing;
  reg [7:0] pri_taskfile_timing;
  reg [31:0] sync_dma_timing;
  reg [11:0] pri_sector_bytes;
  reg [11:0] sec_sector_bytes;
  reg [3:0] feature_latch;
  reg [3:0] mode_bits;
  reg [1:0] ready_meta;
  reg [1:0] ready_sync;
  reg [1:0] irq_last;
  reg [11:0] pri_byte_count;
  reg [11:0] sec_byte_count;
  reg [31:0] next_rdata;
  reg next_hit;
  reg [31:0] sync_mode_view;

  wire access_done = psel & penable & pready;
  wire write_now = access_done & pwrite & ~pslverr;
  wire [7:0] reg_index = paddr[9:2];

  assign read_irdy_wait = bus_master_tuning[`BMT_READ_WAIT];
  assign write_irdy_wait = bus_master_tuning[`BMT_WRITE_WAIT];
  assign fifo_data_advance = bus_master_tuning[`BMT_FIFO_ADVANCE];

  // read-only mode bits folded into the sync dma view
  always @* begin
    sync_mode_view = sync_dma_timing & `SDMA_RW_MASK;
    sync_mode_view[24 + `SDMA_MODE] = mode_bits[0];
    sync_mode_view[16 + `SDMA_MODE] = mode_bits[1];
    sync_mode_view[8 + `SDMA_MODE] = mode_bits[2];
    sync_mode_view[`SDMA_MODE] = mode_bits[3];
  end

  // read decode and unmapped detection
  always @* begin
    next_rdata = 32'h0000_0000;
    next_hit = 1'b1;
    case (reg_index)
      `IDX_BUS_MASTER_TUNING: next_rdata = {24'h00_0000, bus_master_tuning};
      `IDX_INTERRUPT_STEERING: next_rdata = {24'h00_0000, interrupt_steering};
      `IDX_FIFO_FLUSH_CONTROL: next_rdata = {24'h00_0000, fifo_flush_control};
      `IDX_STROBE_TIMING: next_rdata = strobe_timing;
      `IDX_ADDRESS_SETUP: next_rdata = {24'h00_0000, address_setup};
      `IDX_SEC_TASKFILE_TIMING: next_rdata = {24'h00_0000, sec_taskfile_timing};
      `IDX_PRI_TASKFILE_TIMING: next_rdata = {24'h00_0000, pri_taskfile_timing};
      `IDX_SYNC_DMA_TIMING: next_rdata = sync_mode_view;
      `IDX_PRI_SECTOR_BYTES: next_rdata = {20'h0_0000, pri_sector_bytes};
      `IDX_SEC_SECTOR_BYTES: next_rdata = {20'h0_0000, sec_sector_bytes};
      default: next_hit = 1'b0;
    endcase
  end

  // apb slave: answers in the first access cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel & ~penable & ~pready;
      if (psel & ~penable) begin
        pslverr <= ~next_hit;
        prdata <= pwrite ? 32'h0000_0000 : next_rdata;
      end else if (access_done) begin
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
      end
    end
  end

  // register writes
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_master_tuning <= `BMT_RESET;
      interrupt_steering <= `STEER_RESET;
      fifo_flush_control <= `FLUSH_RESET;
      strobe_timing <= `STROBE_RESET;
      address_setup <= `SETUP_RESET;
      sec_taskfile_timing <= `TASKFILE_RESET;
      pri_taskfile_timing <= `TASKFILE_RESET;
      sync_dma_timing <= `SDMA_RESET;
      pri_sector_bytes <= `SECTOR_RESET;
      sec_sector_bytes <= `SECTOR_RESET;
    end else if (write_now) begin
      case (reg_index)
        `IDX_BUS_MASTER_TUNING: bus_master_tuning <= pwdata[7:0] & `BMT_MASK;
        `IDX_INTERRUPT_STEERING: interrupt_steering <= pwdata[7:0] & `STEER_MASK;
        `IDX_FIFO_FLUSH_CONTROL: fifo_flush_control <= pwdata[7:0] & `FLUSH_MASK;
        `IDX_STROBE_TIMING: strobe_timing <= pwdata;
        `IDX_ADDRESS_SETUP: address_setup <= pwdata[7:0];
        `IDX_SEC_TASKFILE_TIMING: sec_taskfile_timing <= pwdata[7:0];
        `IDX_PRI_TASKFILE_TIMING: pri_taskfile_timing <= pwdata[7:0];
        `IDX_SYNC_DMA_TIMING: sync_dma_timing <= pwdata & `SDMA_RW_MASK;
        `IDX_PRI_SECTOR_BYTES: pri_sector_bytes <= pwdata[11:0];
        `IDX_SEC_SECTOR_BYTES: sec_sector_bytes <= pwdata[11:0];
        default: begin
        end
      endcase
    end
  end

  // status read retry and interrupt steering
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      status_read_retry <= 1'b0;
      irq_out <= 2'b00;
      irq_last <= 2'b00;
    end else begin
      status_read_retry <= bus_master_tuning[`BMT_STATUS_RETRY] & status_read_req
        & dma_write_pending;
      irq_last <= channel_irq;
      if (interrupt_steering[`STEER_SWAP]) begin
        irq_out <= {channel_irq[0], channel_irq[1]};
      end else begin
        irq_out <= channel_irq;
      end
    end
  end

  // sector byte counters and fifo flush
  wire [11:0] pri_count_next = pri_byte_count + `BYTES_PER_WORD;
  wire [11:0] sec_count_next = sec_byte_count + `BYTES_PER_WORD;
  wire pri_sector_end = word_moved[0] && (pri_count_next >= pri_sector_bytes);
  wire sec_sector_end = word_moved[1] && (sec_count_next >= sec_sector_bytes);
  wire [1:0] irq_rise = channel_irq & ~irq_last;

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pri_byte_count <= 12'h000;
      sec_byte_count <= 12'h000;
      fifo_flush <= 2'b00;
    end else begin
      if (word_moved[0]) begin
        pri_byte_count <= pri_sector_end ? 12'h000 : pri_count_next;
      end
      if (word_moved[1]) begin
        sec_byte_count <= sec_sector_end ? 12'h000 : sec_count_next;
      end
      fifo_flush[0] <= (fifo_flush_control[`FLUSH_PRI_READ] & irq_rise[0])
        | (fifo_flush_control[`FLUSH_PRI_SECTOR] & pri_sector_end);
      fifo_flush[1] <= (fifo_flush_control[`FLUSH_SEC_READ] & irq_rise[1])
        | (fifo_flush_control[`FLUSH_SEC_SECTOR] & sec_sector_end);
    end
  end

  // drive ready pins cross in through two flip-flops
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ready_meta <= 2'b11;
      ready_sync <= 2'b11;
    end else begin
      ready_meta <= drive_ready_wait_n;
      ready_sync <= ready_meta;
    end
  end

  wire [1:0] limit_code = fifo_flush_control[`FLUSH_LIMIT_HI:`FLUSH_LIMIT_LO];
  wire [7:0] ready_limit = {6'h00, limit_code} * `READY_LIMIT_STEP;

  genvar ch;
  generate
    for (ch = 0; ch < 2; ch = ch + 1) begin : chan
      // drive index 0 is primary drive 0, held in the top byte
      wire [1:0] drive_index = {(ch != 0), cmd_drive[ch]};
      wire [31:0] strobe_shift = strobe_timing << {drive_index, 3'b000};
      wire [7:0] setup_shift = address_setup << {drive_index, 1'b0};
      wire [7:0] taskfile = (ch == 0) ? pri_taskfile_timing : sec_taskfile_timing;
      wire [3:0] active_code = cmd_taskfile[ch] ? taskfile[7:4] : strobe_shift[31:28];
      ide_strobe_sequencer seq (
        .ref_clk(ref_clk),
        .rst(rst),
        .start(cmd_start[ch]),
        .write(cmd_write[ch]),
        .setup_code(setup_shift[7:6]),
        .active_code(active_code),
        .recovery_code(strobe_shift[27:24]),
        .ready_limit(ready_limit),
        .ready_ok(ready_sync[ch]),
        .read_strobe_n(drive_read_strobe_n[ch]),
        .write_strobe_n(drive_write_strobe_n[ch]),
        .busy(strobe_busy[ch]),
        .done(strobe_done[ch]),
        .hang_break(strobe_hang_break[ch])
      );
    end
  endgenerate

  // synchronous dma mode per drive; drive 0 is primary drive 0 in the top byte
  genvar dr;
  generate
    for (dr = 0; dr < 4; dr = dr + 1) begin : drive
      wire [7:0] cfg = sync_dma_timing[31 - 8 * dr -: 8];
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          feature_latch[dr] <= 1'b0;
          mode_bits[dr] <= 1'b0;
          sync_dma_active[dr] <= 1'b0;
          sync_dma_cycle[3 * dr +: 3] <= 3'h5;
        end else begin
          if (set_features_on[dr]) begin
            feature_latch[dr] <= 1'b1;
          end else if (set_features_off[dr]) begin
            feature_latch[dr] <= 1'b0;
          end
          mode_bits[dr] <= pio_based[dr];
          sync_dma_active[dr] <= cfg[`SDMA_METHOD] ? cfg[`SDMA_ENABLE]
            : feature_latch[dr];
          sync_dma_cycle[3 * dr +: 3] <= {1'b0, cfg[1:0]} + `SDMA_CYCLE_BASE;
        end
      end
    end
  endgenerate
endmodule // ide_channel_timing_control

/* File: ide_channel_timing_control_props.sv */
// assertion checker for the ide channel timing control block
module ide_channel_timing_control_props (
  input wire ref_clk, // clock
  input wire rst, // async reset
  input wire psel, // apb select
  input wire penable, // apb access
  input wire pwrite, // apb direction
  input wire [9:0] paddr, // apb address
  input wire [31:0] pwdata, // apb write data
  input wire pready, // apb ready
  input wire status_read_req, // status read
  input wire dma_write_pending, // write pending
  input wire status_read_retry, // retry answer
  input wire read_irdy_wait, // read wait
  input wire write_irdy_wait, // write wait
  input wire fifo_data_advance, // data advance
  input wire [1:0] channel_irq, // raw irq
  input wire [1:0] irq_out, // steered irq
  input wire [1:0] fifo_flush, // flush pulses
  input wire [1:0] drive_read_strobe_n, // read strobes
  input wire [1:0] strobe_busy, // busy
  input wire [1:0] strobe_done, // done
  input wire [11:0] sync_dma_cycle // cycle clocks
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  logic swap_m;
  logic [7:0] flush_m;
  logic [9:0] low_run;
  wire wr_edge = psel && penable && pready && pwrite;
  sequence s_wr(a);
    wr_edge && paddr == a;
  endsequence
  // register mirrors and primary read strobe length
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      swap_m <= 1'b0;
      flush_m <= 8'h00;
      low_run <= 10'h000;
    end else begin
      if (wr_edge && paddr == 10'h114) swap_m <= pwdata[6];
      if (wr_edge && paddr == 10'h118) flush_m <= pwdata[7:0];
      low_run <= drive_read_strobe_n[0] ? 10'h000 : low_run + 10'h001;
    end
  end
  a_apb_zero_wait: assert property (psel && !penable |=> pready)
    else $error("late pready");
  a_read_wait_bit: assert property (s_wr(10'h110) |=> read_irdy_wait == $past(pwdata[6]))
    else $error("read wait bit");
  a_write_wait_bit: assert property (s_wr(10'h110) |=> write_irdy_wait == $past(pwdata[5]))
    else $error("write wait bit");
  a_advance_bit: assert property (s_wr(10'h110) |=> fifo_data_advance == $past(pwdata[4]))
    else $error("advance bit");
  a_retry_cause: assert property (status_read_retry |-> $past(status_read_req && dma_write_pending))
    else $error("stray retry");
  a_irq_steer: assert property (irq_out == ($past(swap_m) ?
    {$past(channel_irq[0]), $past(channel_irq[1])} : $past(channel_irq)))
    else $error("bad irq steering");
  a_irq_flush: assert property ($rose(channel_irq[0]) && flush_m[7] |=> fifo_flush[0])
    else $error("no irq flush");
  a_flush_gate: assert property (fifo_flush[1] |-> $past(flush_m[6] || flush_m[4]))
    else $error("stray flush");
  a_hang_limit: assert property (flush_m[1:0] != 2'b00 |->
    low_run <= {2'b00, flush_m[1:0], 6'h00})
    else $error("hang limit passed");
  a_done_fall: assert property (strobe_done[0] |-> $fell(strobe_busy[0]))
    else $error("done not at busy end");
  a_cycle_map: assert property (s_wr(10'h140) |=> ##1
    sync_dma_cycle[2:0] == {1'b0, $past(pwdata[25:24], 2)} + 3'h2)
    else $error("bad cycle clocks");
endmodule // ide_channel_timing_control_props

bind ide_channel_timing_control ide_channel_timing_control_props u_props (.*);

/* File: ide_drive_model.sv */
// behavioural ide drive that can hold its ready line low during a strobe
module ide_drive_model (
  input wire logic ref_clk, // clock
  input wire logic read_strobe_n, // read strobe, active low
  input wire logic write_strobe_n, // write strobe, active low
  input wire logic [15:0] hold_clocks, // clocks ready is held low per strobe
  output wire logic drive_ready_wait_n // low while the drive stretches the strobe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] held = 16'h0000;
  always @(posedge ref_clk) begin
    if (read_strobe_n && write_strobe_n) held <= 16'h0000;
    else if (held < hold_clocks) held <= held + 16'h0001;
  end
  // pulled up, so the line rises as soon as no strobe is active
  assign drive_ready_wait_n = (read_strobe_n && write_strobe_n) || (held >= hold_clocks);
endmodule // ide_drive_model

/* File: ide_channel_timing_control_bench.sv */
// self-checking bench for the ide channel timing control block
module ide_channel_timing_control_bench;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [9:0] a; logic [31:0] rv; logic [31:0] wv; logic [31:0] bv;} row_t;
  logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic status_read_req = 1'b0, dma_write_pending = 1'b0, e;
  logic [9:0] paddr = 10'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, q;
  logic pready, pslverr, status_read_retry, read_irdy_wait, write_irdy_wait, fifo_data_advance;
  logic [1:0] channel_irq = 2'b00, word_moved = 2'b00, cmd_start = 2'b00, cmd_write = 2'b00;
  logic [1:0] cmd_drive = 2'b00, cmd_taskfile = 2'b00, irq_out, fifo_flush;
  logic [1:0] drive_read_strobe_n, drive_write_strobe_n, strobe_busy, strobe_done;
  logic [1:0] strobe_hang_break;
  wire [1:0] drive_ready_wait_n;
  logic [3:0] set_features_on = 4'h0, set_features_off = 4'h0, pio_based = 4'h0;
  logic [3:0] sync_dma_active;
  logic [11:0] sync_dma_cycle;
  logic [15:0] hold [2] = '{16'h0000, 16'h0000};
  int failures = 0, samples_checked = 0, flushes [2] = '{0, 0}, hangs = 0;
  row_t rows [11] = '{
    '{10'h110, 32'h0000_0068, 32'hFFFF_FFFF, 32'h0000_007B},
    '{10'h114, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0040},
    '{10'h118, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_00F3},
    '{10'h120, 32'hA8A8_A8A8, 32'h2345_6714, 32'h2345_6714},
    '{10'h130, 32'h0000_00FF, 32'h0000_004B, 32'h0000_004B},
    '{10'h138, 32'h0000_00F0, 32'h0000_00A5, 32'h0000_00A5},
    '{10'h13C, 32'h0000_00F0, 32'h0000_0050, 32'h0000_0050},
    '{10'h140, 32'h0303_0303, 32'hFFFF_FFFF, 32'hC3C3_C3C3},
    '{10'h180, 32'h0000_0200, 32'hFFFF_FFFF, 32'h0000_0FFF},
    '{10'h1A0, 32'h0000_0200, 32'h0000_1234, 32'h0000_0234},
    '{10'h3FC, 32'h0000_0000, 32'hFFFF_FFFF, 32'h0000_0000}
  };
  ide_channel_timing_control u_ide_channel_timing_control (
    .ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .status_read_req, .dma_write_pending, .status_read_retry, .read_irdy_wait,
    .write_irdy_wait, .fifo_data_advance, .channel_irq, .irq_out, .fifo_flush, .word_moved,
    .cmd_start, .cmd_write, .cmd_drive, .cmd_taskfile, .drive_ready_wait_n,
    .drive_read_strobe_n, .drive_write_strobe_n, .strobe_busy, .strobe_done,
    .strobe_hang_break, .set_features_on, .set_features_off, .pio_based, .sync_dma_active,
    .sync_dma_cycle
  );
  ide_drive_model u_drive_pri (.ref_clk, .read_strobe_n(drive_read_strobe_n[0]),
    .write_strobe_n(drive_write_strobe_n[0]), .hold_clocks(hold[0]),
    .drive_ready_wait_n(drive_ready_wait_n[0]));
  ide_drive_model u_drive_sec (.ref_clk, .read_strobe_n(drive_read_strobe_n[1]),
    .write_strobe_n(drive_write_strobe_n[1]), .hold_clocks(hold[1]),
    .drive_ready_wait_n(drive_ready_wait_n[1]));
  always #5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (fifo_flush[0] === 1'b1) flushes[0] <= flushes[0] + 1;
    if (fifo_flush[1] === 1'b1) flushes[1] <= flushes[1] + 1;
    if (strobe_hang_break[0] === 1'b1) hangs <= hangs + 1;
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // one apb transfer and an idle cycle; read data in q, error in e
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    while (pready !== 1'b1) @(posedge ref_clk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  // one strobe, its phases counted at falling edges
  task automatic strobe(input int ch, input int drv, input int w, input int tf, input int su,
      input int act, input int rec);
    int n = 1, m = 0, k = 0;
    cmd_drive[ch] <= drv[0];
    cmd_write[ch] <= w[0];
    cmd_taskfile[ch] <= tf[0];
    cmd_start[ch] <= 1'b1;
    @(posedge ref_clk);
    cmd_start[ch] <= 1'b0;
    @(negedge ref_clk);
    while ((w ? drive_write_strobe_n[ch] : drive_read_strobe_n[ch]) !== 1'b0) begin
      n++;
      @(negedge ref_clk);
    end
    while ((w ? drive_write_strobe_n[ch] : drive_read_strobe_n[ch]) === 1'b0) begin
      m++;
      @(negedge ref_clk);
    end
    while (strobe_done[ch] !== 1'b1) begin
      k++;
      @(negedge ref_clk);
    end
    chk("setup clocks", n, su + 2);
    chk("active clocks", m, act + 1);
    chk("recovery clocks", k, rec + 1);
    @(posedge ref_clk);
  endtask
  task automatic results();
    if (failures == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    #300us;
    failures++;
    results();
  end
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("reset value", q, rows[i].rv);
      chk("slave error", 32'(e), 32'(rows[i].a == 10'h3FC));
      apb(1'b1, rows[i].a, rows[i].wv);
      apb(1'b0, rows[i].a, 32'h0000_0000);
      chk("readback", q, rows[i].bv);
    end
    chk("wait bits", 32'({read_irdy_wait, write_irdy_wait, fifo_data_advance}), 32'h7);
    chk("sync active", 32'(sync_dma_active), 32'h0000_000F);
    chk("sync cycle", 32'(sync_dma_cycle), 32'h0000_0B6D);
    status_read_req <= 1'b1;
    dma_write_pending <= 1'b1;
    tick(2);
    chk("retry", 32'(status_read_retry), 32'h0000_0001);
    apb(1'b1, 10'h110, 32'h0000_0000);
    tick(2);
    chk("tuning off", 32'({status_read_retry, read_irdy_wait, write_irdy_wait,
      fifo_data_advance}), 32'h0000_0000);
    channel_irq <= 2'b01;
    tick(3);
    chk("swapped irq", 32'(irq_out), 32'h0000_0002);
    chk("irq flush", 32'(flushes[0] * 16 + flushes[1]), 32'h0000_0010);
    apb(1'b1, 10'h114, 32'h0000_0000);
    apb(1'b1, 10'h118, 32'h0000_0030);
    channel_irq <= 2'b10;
    apb(1'b1, 10'h180, 32'h0000_0008);
    apb(1'b1, 10'h1A0, 32'h0000_0006);
    chk("direct irq", 32'(irq_out), 32'h0000_0002);
    word_moved <= 2'b11;
    tick(6);
    word_moved <= 2'b00;
    tick(2);
    chk("sector flush", 32'(flushes[0] * 16 + flushes[1]), 32'h0000_0022);
    channel_irq <= 2'b00;
    strobe(0, 0, 0, 0, 1, 2, 3);
    strobe(1, 1, 1, 0, 3, 1, 4);
    strobe(0, 1, 0, 1, 0, 5, 5);
    hold[0] <= 16'hFFFF;
    for (int c = 1; c < 4; c++) begin
      apb(1'b1, 10'h118, 32'(c));
      strobe(0, 0, 0, 0, 1, 64 * c - 1, 3);
    end
    chk("hang breaks", 32'(hangs), 32'h0000_0003);
    hold[0] <= 16'h0000;
    apb(1'b1, 10'h140, 32'h0001_0203);
    tick(2);
    chk("cycle codes", 32'(sync_dma_cycle), 32'h0000_0B1A);
    set_features_on <= 4'h1;
    tick(1);
    set_features_on <= 4'h0;
    tick(2);
    chk("feature on", 32'(sync_dma_active), 32'h0000_0001);
    apb(1'b1, 10'h140, 32'hC000_0000);
    set_features_off <= 4'h1;
    tick(1);
    set_features_off <= 4'h0;
    tick(2);
    chk("enable wins", 32'(sync_dma_active), 32'h0000_0001);
    apb(1'b1, 10'h140, 32'h8000_0000);
    pio_based <= 4'h1;
    tick(2);
    chk("enable off", 32'(sync_dma_active), 32'h0000_0000);
    apb(1'b0, 10'h140, 32'h0000_0000);
    chk("pio mode", q, 32'hA000_0000);
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    tick(1);
    apb(1'b0, 10'h140, 32'h0000_0000);
    chk("sync after reset", q, 32'h2303_0303);
    apb(1'b0, 10'h120, 32'h0000_0000);
    chk("strobe after reset", q, 32'hA8A8_A8A8);
    chk("waits after reset", 32'({read_irdy_wait, write_irdy_wait, fifo_data_advance}), 32'h6);
    results();
  end
endmodule // ide_channel_timing_control_bench
